// File: include/ccc_params.svh
// constants for the conditional call and compare block
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH
`define CCC_OP_CALL_REL 8'h6e
`define CCC_OP_CALL_ABS 8'h69
`define CCC_OP_CMP_TC1  8'hf0
`define CCC_OP_CMP_TC2  8'hf1
`define CCC_SIZE_REL    24'h000004
`define CCC_SIZE_ABS    24'h000005
`define CCC_SIZE_CMP    24'h000004
`define CCC_CYC_REL_T   4'h6
`define CCC_CYC_REL_F   4'h5
`define CCC_CYC_ABS_T   4'h5
`define CCC_CYC_ABS_F   4'h5
`define CCC_A_CTRL      12'h000
`define CCC_A_FLAGS     12'h004
`define CCC_A_INSN0     12'h008
`define CCC_A_INSN1     12'h00c
`define CCC_A_PC        12'h010
`define CCC_A_ACC_LO    12'h014
`define CCC_A_ACC_HI    12'h018
`define CCC_A_DSP       12'h01c
`define CCC_A_SSP       12'h020
`define CCC_A_LOOP      12'h024
`define CCC_A_RET_PAIR  12'h028
`define CCC_A_REPEAT    12'h02c
`define CCC_A_RESULT    12'h030
`define CCC_DMEM_REGION 2'h1
`define CCC_CTRL_GO     0
`define CCC_CTRL_FAST   1
`define CCC_CTRL_LEGACY 2
`define CCC_CTRL_WIDE   3
`define CCC_FL_TC1      0
`define CCC_FL_TC2      1
`define CCC_FL_CARRY    2
`define CCC_FL_ACOV     3
`define CCC_CC_OV       7'h08
`define CCC_CC_NOV      7'h09
`define CCC_CC_C        7'h0a
`define CCC_CC_NC       7'h0b
`define CCC_CC_TC1      7'h0c
`define CCC_CC_TC2      7'h0d
`define CCC_CC_NTC1     7'h0e
`define CCC_CC_NTC2     7'h0f
`define CCC_DSP_RST     16'h0000
`define CCC_SSP_RST     16'h0000
`endif

// File: include/ccc_pkg.sv
// types for the conditional call and compare block
package ccc_pkg;
    typedef enum logic [3:0] {
        CCC_IDLE = 4'h1,
        CCC_COND = 4'h2,
        CCC_HOLD = 4'h4,
        CCC_CMP  = 4'h8
    } ccc_state_t;
endpackage

// File: core/ccc_top.sv
// conditional call and memory compare execution unit with ahb-lite access
//
// Overview of operation
// - condition judged in read stage; else sequential
// - target is 16-bit relative or 24-bit absolute
// - status updates reach condition one cycle late
// - relative call: 4 bytes, 6/5 cycles
// - absolute call: 5 bytes, 5/5 cycles
// - opcodes 01101110 and 01101001, 7-bit condition
// - default saves pc and loop context to stacks
// - fast mode saves to return and context registers
// - return pair accessed only as one word
// - data stack decrements, pushes return low half
// - system stack pushes loop bits, return high byte
// - then pc gets target, active flags cleared
// - call never repeats, executes once
// - legacy mode tests accumulators at 40 bits
// - condition may modify only the overflow flag
// - compare memory word with constant, set flag
// - opcodes 11110000/11110001 pick test flag one/two
// - compare: 4 bytes, one execute cycle
// - compare repeats, updating flag every iteration
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ccc_params.svh"

module ccc_top
    import ccc_pkg::*;
#(
    parameter int DMEM_WORDS = 256
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // stack write ports
    output logic             dstack_we,
    output logic      [15:0] dstack_addr,
    output logic      [15:0] dstack_wdata,
    output logic             sstack_we,
    output logic      [15:0] sstack_addr,
    output logic      [15:0] sstack_wdata,
    // activity
    output logic             busy
);

    logic        rst_s1_r;
    logic        rst_n_r;
    logic        pend_r;
    logic        pend_nxt;
    logic        pwrite_r;
    logic        pwrite_nxt;
    logic [11:0] paddr_r;
    logic [11:0] paddr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic        hready_r;
    logic        hready_nxt;
    logic [31:0] rd_val;
    logic        wr_en;
    logic        dm_sel;
    logic [15:0] dmem [DMEM_WORDS];

    ccc_state_t  state_r;
    ccc_state_t  state_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    logic        fast_r;
    logic        fast_nxt;
    logic        legacy_r;
    logic        legacy_nxt;
    logic        wide_r;
    logic        wide_nxt;
    logic [3:0]  flags_r;
    logic [3:0]  flags_nxt;
    logic [3:0]  flags_d_r;
    logic [39:0] insn_r;
    logic [39:0] insn_nxt;
    logic [23:0] pc_r;
    logic [23:0] pc_nxt;
    logic [39:0] acc_r;
    logic [39:0] acc_nxt;
    logic [15:0] dsp_r;
    logic [15:0] dsp_nxt;
    logic [15:0] ssp_r;
    logic [15:0] ssp_nxt;
    logic [7:0]  loop_ctx_r;
    logic [7:0]  loop_ctx_nxt;
    logic [23:0] return_address_reg_r;
    logic [23:0] return_address_reg_nxt;
    logic [7:0]  fctx_r;
    logic [7:0]  fctx_nxt;
    logic [7:0]  rpt_r;
    logic [7:0]  rpt_nxt;
    logic [7:0]  rpt_cnt_r;
    logic [7:0]  rpt_cnt_nxt;
    logic        taken_r;
    logic        taken_nxt;
    logic        illegal_r;
    logic        illegal_nxt;
    logic [23:0] target_r;
    logic [23:0] target_nxt;
    logic        dwe_nxt;
    logic [15:0] dad_nxt;
    logic [15:0] dwd_nxt;
    logic        swe_nxt;
    logic [15:0] sad_nxt;
    logic [15:0] swd_nxt;
    logic        dwe_r;
    logic [15:0] dad_r;
    logic [15:0] dwd_r;
    logic        swe_r;
    logic [15:0] sad_r;
    logic [15:0] swd_r;
    logic        busy_r;

    logic        is_rel;
    logic        cond_ok;
    logic        wide_test;
    logic [23:0] ret_addr;
    logic [15:0] cmp_word;

    // reset asserts at once and is released through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // subset of the condition-code table; other codes read as false
    function automatic logic cond_eval(input logic [6:0]  cc,
                                       input logic [3:0]  fl,
                                       input logic [39:0] acc,
                                       input logic        wide);
        logic [39:0] a;
        logic        z;
        logic        n;
        logic        r;
        a = wide ? acc : {{8{acc[31]}}, acc[31:0]};
        z = (a == 40'h0);
        n = a[39];
        r = 1'b0;
        if (cc[6:3] == 4'h0) begin
            case (cc[2:0])
                3'h0:    r = z;
                3'h1:    r = !z;
                3'h2:    r = n;
                3'h3:    r = n | z;
                3'h4:    r = !n & !z;
                3'h5:    r = !n;
                default: r = 1'b0;
            endcase
        end else begin
            case (cc)
                `CCC_CC_OV:   r = fl[`CCC_FL_ACOV];
                `CCC_CC_NOV:  r = !fl[`CCC_FL_ACOV];
                `CCC_CC_C:    r = fl[`CCC_FL_CARRY];
                `CCC_CC_NC:   r = !fl[`CCC_FL_CARRY];
                `CCC_CC_TC1:  r = fl[`CCC_FL_TC1];
                `CCC_CC_TC2:  r = fl[`CCC_FL_TC2];
                `CCC_CC_NTC1: r = !fl[`CCC_FL_TC1];
                `CCC_CC_NTC2: r = !fl[`CCC_FL_TC2];
                default:      r = 1'b0;
            endcase
        end
        return r;
    endfunction

    // bus: one wait state per transfer so reads always see prior writes
    assign wr_en  = pend_r & pwrite_r;
    assign dm_sel = (paddr_r[11:10] == `CCC_DMEM_REGION);

    always_comb begin
        rd_val = 32'h0;
        if (dm_sel) begin
            rd_val = {16'h0, dmem[paddr_r[9:2]]};
        end else begin
            case (paddr_r)
                `CCC_A_CTRL:     rd_val = {28'h0, wide_r, legacy_r,
                                           fast_r, 1'b0};
                `CCC_A_FLAGS:    rd_val = {28'h0, flags_r};
                `CCC_A_INSN0:    rd_val = insn_r[39:8];
                `CCC_A_INSN1:    rd_val = {24'h0, insn_r[7:0]};
                `CCC_A_PC:       rd_val = {8'h0, pc_r};
                `CCC_A_ACC_LO:   rd_val = acc_r[31:0];
                `CCC_A_ACC_HI:   rd_val = {24'h0, acc_r[39:32]};
                `CCC_A_DSP:      rd_val = {16'h0, dsp_r};
                `CCC_A_SSP:      rd_val = {16'h0, ssp_r};
                `CCC_A_LOOP:     rd_val = {24'h0, loop_ctx_r};
                `CCC_A_RET_PAIR: rd_val = {fctx_r, return_address_reg_r};
                `CCC_A_REPEAT:   rd_val = {24'h0, rpt_r};
                `CCC_A_RESULT:   rd_val = {29'h0, illegal_r, taken_r,
                                           busy_r};
                default:         rd_val = 32'h0;
            endcase
        end
    end

    always_comb begin
        pend_nxt   = 1'b0;
        pwrite_nxt = pwrite_r;
        paddr_nxt  = paddr_r;
        hready_nxt = 1'b1;
        hrdata_nxt = hrdata_r;
        if (hsel && htrans[1] && hready) begin
            pend_nxt   = 1'b1;
            pwrite_nxt = hwrite;
            paddr_nxt  = {haddr[11:2], 2'h0};
            hready_nxt = 1'b0;
        end
        if (pend_r && !pwrite_r) begin
            hrdata_nxt = rd_val;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pend_r   <= 1'b0;
            pwrite_r <= 1'b0;
            paddr_r  <= 12'h0;
            hrdata_r <= 32'h0;
            hready_r <= 1'b1;
        end else begin
            pend_r   <= pend_nxt;
            pwrite_r <= pwrite_nxt;
            paddr_r  <= paddr_nxt;
            hrdata_r <= hrdata_nxt;
            hready_r <= hready_nxt;
        end
    end

    // data memory has no reset; software loads it before use
    always_ff @(posedge clk) begin
        if (wr_en && dm_sel) begin
            dmem[paddr_r[9:2]] <= hwdata[15:0];
        end
    end

    // status seen by the condition logic lags one cycle
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flags_d_r <= 4'h0;
        end else begin
            flags_d_r <= flags_r;
        end
    end

    assign is_rel    = (insn_r[39:32] == `CCC_OP_CALL_REL);
    assign wide_test = wide_r | legacy_r;
    assign cond_ok   = cond_eval(insn_r[30:24], flags_d_r, acc_r,
                                 wide_test);
    assign ret_addr  = pc_r + (is_rel ? `CCC_SIZE_REL : `CCC_SIZE_ABS);
    assign cmp_word  = dmem[insn_r[31:24]];

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        fast_nxt     = fast_r;
        legacy_nxt   = legacy_r;
        wide_nxt     = wide_r;
        flags_nxt    = flags_r;
        insn_nxt     = insn_r;
        pc_nxt       = pc_r;
        acc_nxt      = acc_r;
        dsp_nxt      = dsp_r;
        ssp_nxt      = ssp_r;
        loop_ctx_nxt = loop_ctx_r;
        return_address_reg_nxt     = return_address_reg_r;
        fctx_nxt     = fctx_r;
        rpt_nxt      = rpt_r;
        rpt_cnt_nxt  = rpt_cnt_r;
        taken_nxt    = taken_r;
        illegal_nxt  = illegal_r;
        target_nxt   = target_r;
        dwe_nxt      = 1'b0;
        dad_nxt      = dad_r;
        dwd_nxt      = dwd_r;
        swe_nxt      = 1'b0;
        sad_nxt      = sad_r;
        swd_nxt      = swd_r;
        // software writes first; hardware updates below win
        if (wr_en && !dm_sel) begin
            case (paddr_r)
                `CCC_A_CTRL: begin
                    fast_nxt   = hwdata[`CCC_CTRL_FAST];
                    legacy_nxt = hwdata[`CCC_CTRL_LEGACY];
                    wide_nxt   = hwdata[`CCC_CTRL_WIDE];
                end
                `CCC_A_FLAGS:    flags_nxt = hwdata[3:0];
                `CCC_A_INSN0:    insn_nxt[39:8] = hwdata;
                `CCC_A_INSN1:    insn_nxt[7:0] = hwdata[7:0];
                `CCC_A_PC:       pc_nxt = hwdata[23:0];
                `CCC_A_ACC_LO:   acc_nxt[31:0] = hwdata;
                `CCC_A_ACC_HI:   acc_nxt[39:32] = hwdata[7:0];
                `CCC_A_DSP:      dsp_nxt = hwdata[15:0];
                `CCC_A_SSP:      ssp_nxt = hwdata[15:0];
                `CCC_A_LOOP:     loop_ctx_nxt = hwdata[7:0];
                `CCC_A_RET_PAIR: begin
                    return_address_reg_nxt = hwdata[23:0];
                    fctx_nxt = hwdata[31:24];
                end
                `CCC_A_REPEAT:   rpt_nxt = hwdata[7:0];
                default: begin
                end
            endcase
        end
        case (state_r)
            CCC_IDLE: begin
                if (wr_en && !dm_sel && paddr_r == `CCC_A_CTRL &&
                    hwdata[`CCC_CTRL_GO]) begin
                    taken_nxt   = 1'b0;
                    illegal_nxt = 1'b0;
                    case (insn_r[39:32])
                        `CCC_OP_CALL_REL, `CCC_OP_CALL_ABS: begin
                            state_nxt = CCC_COND;
                        end
                        `CCC_OP_CMP_TC1, `CCC_OP_CMP_TC2: begin
                            rpt_cnt_nxt = rpt_r;
                            state_nxt   = CCC_CMP;
                        end
                        default: illegal_nxt = 1'b1;
                    endcase
                end
            end
            CCC_COND: begin
                // read stage: repeat count ignored, runs once
                taken_nxt = cond_ok;
                if (insn_r[30:24] == `CCC_CC_OV ||
                    insn_r[30:24] == `CCC_CC_NOV) begin
                    flags_nxt[`CCC_FL_ACOV] = 1'b0;
                end
                if (is_rel) begin
                    target_nxt = ret_addr +
                        {{8{insn_r[23]}}, insn_r[23:8]};
                    cnt_nxt = cond_ok ? `CCC_CYC_REL_T
                                      : `CCC_CYC_REL_F;
                end else begin
                    target_nxt = insn_r[23:0];
                    cnt_nxt = cond_ok ? `CCC_CYC_ABS_T
                                      : `CCC_CYC_ABS_F;
                end
                cnt_nxt = cnt_nxt - 4'h2;
                if (cond_ok) begin
                    if (fast_r) begin
                        return_address_reg_nxt = ret_addr;
                        fctx_nxt = loop_ctx_r;
                    end else begin
                        dsp_nxt = dsp_r - 16'h1;
                        dad_nxt = dsp_r - 16'h1;
                        dwd_nxt = ret_addr[15:0];
                        dwe_nxt = 1'b1;
                        ssp_nxt = ssp_r - 16'h1;
                        sad_nxt = ssp_r - 16'h1;
                        swd_nxt = {loop_ctx_r, ret_addr[23:16]};
                        swe_nxt = 1'b1;
                    end
                    loop_ctx_nxt = 8'h0;
                end
                state_nxt = CCC_HOLD;
            end
            CCC_HOLD: begin
                // pads the call out to its documented length
                if (cnt_r == 4'h0) begin
                    pc_nxt    = taken_r ? target_r : ret_addr;
                    state_nxt = CCC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            CCC_CMP: begin
                // one execute cycle per iteration, no status read
                if (insn_r[32]) begin
                    flags_nxt[`CCC_FL_TC2] =
                        (cmp_word == insn_r[23:8]);
                end else begin
                    flags_nxt[`CCC_FL_TC1] =
                        (cmp_word == insn_r[23:8]);
                end
                if (rpt_cnt_r == 8'h0) begin
                    pc_nxt    = pc_r + `CCC_SIZE_CMP;
                    state_nxt = CCC_IDLE;
                end else begin
                    rpt_cnt_nxt = rpt_cnt_r - 8'h1;
                end
            end
            default: state_nxt = CCC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r    <= CCC_IDLE;
            cnt_r      <= 4'h0;
            fast_r     <= 1'b0;
            legacy_r   <= 1'b0;
            wide_r     <= 1'b0;
            flags_r    <= 4'h0;
            insn_r     <= 40'h0;
            pc_r       <= 24'h0;
            acc_r      <= 40'h0;
            dsp_r      <= `CCC_DSP_RST;
            ssp_r      <= `CCC_SSP_RST;
            loop_ctx_r <= 8'h0;
            return_address_reg_r     <= 24'h0;
            fctx_r     <= 8'h0;
            rpt_r      <= 8'h0;
            rpt_cnt_r  <= 8'h0;
            taken_r    <= 1'b0;
            illegal_r  <= 1'b0;
            target_r   <= 24'h0;
            dwe_r      <= 1'b0;
            dad_r      <= 16'h0;
            dwd_r      <= 16'h0;
            swe_r      <= 1'b0;
            sad_r      <= 16'h0;
            swd_r      <= 16'h0;
            busy_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            fast_r     <= fast_nxt;
            legacy_r   <= legacy_nxt;
            wide_r     <= wide_nxt;
            flags_r    <= flags_nxt;
            insn_r     <= insn_nxt;
            pc_r       <= pc_nxt;
            acc_r      <= acc_nxt;
            dsp_r      <= dsp_nxt;
            ssp_r      <= ssp_nxt;
            loop_ctx_r <= loop_ctx_nxt;
            return_address_reg_r     <= return_address_reg_nxt;
            fctx_r     <= fctx_nxt;
            rpt_r      <= rpt_nxt;
            rpt_cnt_r  <= rpt_cnt_nxt;
            taken_r    <= taken_nxt;
            illegal_r  <= illegal_nxt;
            target_r   <= target_nxt;
            dwe_r      <= dwe_nxt;
            dad_r      <= dad_nxt;
            dwd_r      <= dwd_nxt;
            swe_r      <= swe_nxt;
            sad_r      <= sad_nxt;
            swd_r      <= swd_nxt;
            busy_r     <= (state_nxt != CCC_IDLE);
        end
    end

    assign hrdata       = hrdata_r;
    assign hreadyout    = hready_r;
    assign hresp        = 1'b0;
    assign dstack_we    = dwe_r;
    assign dstack_addr  = dad_r;
    assign dstack_wdata = dwd_r;
    assign sstack_we    = swe_r;
    assign sstack_addr  = sad_r;
    assign sstack_wdata = swd_r;
    assign busy         = busy_r;

endmodule

`default_nettype wire

// File: sim/ccc_checker.sv
// port assertions for the conditional call and compare unit
`timescale 1ns/1ps
`default_nettype none

module ccc_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // register bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // stack write ports
    input wire logic        dstack_we,
    input wire logic [15:0] dstack_addr,
    input wire logic [15:0] dstack_wdata,
    input wire logic        sstack_we,
    input wire logic [15:0] sstack_addr,
    input wire logic [15:0] sstack_wdata,
    // activity
    input wire logic        busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_wait_one: assert property (hsel && htrans[1] && hready
        |=> !hreadyout ##1 hreadyout)
        else $error("ready low not exactly one cycle");
    chk_push_pulse: assert property (dstack_we |=> !dstack_we)
        else $error("data push longer than one cycle");
    chk_push_pair: assert property (dstack_we == sstack_we)
        else $error("stack pushes not paired");
    chk_push_stage: assert property (dstack_we |-> $past(busy)
        && !$past(busy, 2))
        else $error("push not in second busy cycle");
    // push only happens on a taken call, so the run must end at 5 or 6
    chk_push_end: assert property (dstack_we |-> busy
        ##1 busy[*3] ##[1:2] !busy)
        else $error("taken call length wrong");
    chk_dstack_hold: assert property (!dstack_we |->
        $stable(dstack_addr) && $stable(dstack_wdata))
        else $error("data stack port moved without push");
    chk_sstack_hold: assert property (!sstack_we |->
        $stable(sstack_addr) && $stable(sstack_wdata))
        else $error("system stack port moved without push");
endmodule

bind ccc_top ccc_checker ccc_checker_inst (
    .clk          (clk),
    .reset_n      (reset_n),
    .hsel         (hsel),
    .htrans       (htrans),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .dstack_we    (dstack_we),
    .dstack_addr  (dstack_addr),
    .dstack_wdata (dstack_wdata),
    .sstack_we    (sstack_we),
    .sstack_addr  (sstack_addr),
    .sstack_wdata (sstack_wdata),
    .busy         (busy)
);

`default_nettype wire

// File: sim/ccc_top_test.sv
// self-checking bench of the conditional call and compare unit
`timescale 1ns/1ps
`default_nettype none
`include "ccc_params.svh"

module ccc_top_test;
    logic        clk     = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, dstack_we, sstack_we, busy;
    logic [15:0] dstack_addr, dstack_wdata, sstack_addr, sstack_wdata;
    int          num_errors = 0;
    int          n_tests = 0;
    logic [31:0] seed = 32'h10;
    int          j, k, a, cyc;
    logic [31:0] r, v, scratch;
    logic [23:0] pc, ret, tgt, t24;
    logic [15:0] off, dsp, system_stack_pointer, pa, pd, qa, qd, kc;
    logic [7:0]  lp;
    logic [3:0]  fl;
    logic        rel, tk, pushed;
    // call table: opcode, condition, mode, flags, acc high, taken
    logic [7:0]  t_op [8] = '{8'h6e, 8'h6e, 8'h69, 8'h69, 8'h6e, 8'h6e,
                              8'h69, 8'h69};
    logic [6:0]  t_cc [8] = '{7'h0c, 7'h0e, 7'h0a, 7'h0b, 7'h00, 7'h00,
                              7'h08, 7'h01};
    logic [3:0]  t_ctl [8] = '{4'h0, 4'h0, 4'h2, 4'h0, 4'h4, 4'h0, 4'h0, 4'h8};
    logic [3:0]  t_fl [8] = '{4'h1, 4'h1, 4'h4, 4'h4, 4'h0, 4'h0, 4'h8, 4'h0};
    logic [7:0]  t_ah [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h0, 8'h1};
    logic        t_tk [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    always #5 clk = ~clk;
    assign hready = hreadyout;

    ccc_top #(.DMEM_WORDS(256)) ccc_top_inst (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .dstack_we(dstack_we), .dstack_addr(dstack_addr),
        .dstack_wdata(dstack_wdata), .sstack_we(sstack_we),
        .sstack_addr(sstack_addr), .sstack_wdata(sstack_wdata), .busy(busy)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait on ready; a hung slave ends the run
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            $display("wait for ready ran out at %0t", $time);
            results();
        end
    endtask

    task ahb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, ad};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task wr(input logic [11:0] ad, input logic [31:0] wd);
        ahb(1'b1, ad, wd, scratch);
    endtask

    task rd(input logic [11:0] ad, output logic [31:0] rv);
        ahb(1'b0, ad, 32'h0, rv);
    endtask

    // start one instruction, count busy cycles and catch the push
    task run(input logic [31:0] i0, input logic [7:0] i1, input logic [3:0] c);
        int n;
        wr(`CCC_A_INSN0, i0);
        wr(`CCC_A_INSN1, {24'h0, i1});
        wr(`CCC_A_CTRL, {28'h0, c | 4'h1});
        pushed = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        cyc = 0;
        while (busy === 1'b1 && cyc < 300) begin
            @(posedge clk);
            cyc++;
            if (dstack_we === 1'b1) begin
                pushed = 1'b1;
                {pa, pd, qa, qd} = {dstack_addr, dstack_wdata,
                                    sstack_addr, sstack_wdata};
            end
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (a = 0; a <= 'h30; a += 4) begin
            rd(12'(a), v);
            chk(v, 32'h0);
        end
        rd(12'h100, v);
        chk(v, 32'h0);
        $display("test reset and unmapped done");
        for (k = 0; k < 4; k++) begin
            r = xs();
            fl = xs() & 4'hf;
            kc = k[1] ? r[23:8] ^ 16'h0001 : r[23:8];
            wr(`CCC_A_FLAGS, {28'h0, fl});
            wr(12'h400 + {2'h0, r[7:0], 2'h0}, {16'h0, r[23:8]});
            wr(`CCC_A_REPEAT, 32'(k));
            run({7'h78, k[0], r[7:0], kc}, 8'h0, 4'h0);
            chk(32'(cyc), 32'(k + 1));
            fl[k[0]] = !k[1];
            rd(`CCC_A_FLAGS, v);
            chk(v, {28'h0, fl});
        end
        $display("test compare done");
        for (j = 0; j < 8; j++) begin
            pc = xs() & 24'hffffff;
            off = xs() & 16'hffff;
            t24 = xs() & 24'hffffff;
            lp = xs() & 8'hff;
            dsp = 16'h0100 + 16'(j);
            system_stack_pointer = 16'h0200 + 16'(j);
            rel = t_op[j] == 8'h6e;
            tk = t_tk[j];
            ret = pc + (rel ? 24'h4 : 24'h5);
            tgt = rel ? pc + 24'h4 + {{8{off[15]}}, off} : t24;
            wr(`CCC_A_PC, {8'h0, pc});
            wr(`CCC_A_DSP, {16'h0, dsp});
            wr(`CCC_A_SSP, {16'h0, system_stack_pointer});
            wr(`CCC_A_LOOP, {24'h0, lp});
            wr(`CCC_A_FLAGS, {28'h0, t_fl[j]});
            wr(`CCC_A_ACC_LO, 32'h0);
            wr(`CCC_A_ACC_HI, {24'h0, t_ah[j]});
            wr(`CCC_A_REPEAT, 32'h2);
            run({t_op[j], 1'b0, t_cc[j], rel ? off : t24[23:8]}, t24[7:0],
                t_ctl[j]);
            chk(32'(cyc), rel && tk ? 32'h6 : 32'h5);
            tk = tk && !t_ctl[j][1];
            chk({31'h0, pushed}, {31'h0, tk});
            if (tk) begin
                chk({pa, pd}, {dsp - 16'h1, ret[15:0]});
                chk({qa, qd}, {system_stack_pointer - 16'h1, lp, ret[23:16]});
            end
            rd(`CCC_A_DSP, v);
            chk(v, {16'h0, tk ? dsp - 16'h1 : dsp});
            rd(`CCC_A_SSP, v);
            chk(v, {16'h0, tk ? system_stack_pointer - 16'h1 : system_stack_pointer});
            tk = t_tk[j];
            rd(`CCC_A_PC, v);
            chk(v, {8'h0, tk ? tgt : ret});
            rd(`CCC_A_LOOP, v);
            chk(v, tk ? 32'h0 : {24'h0, lp});
            if (tk && t_ctl[j][1]) begin
                rd(`CCC_A_RET_PAIR, v);
                chk(v, {lp, ret});
            end
            rd(`CCC_A_FLAGS, v);
            chk(v, {28'h0, t_fl[j] & (t_cc[j] == 7'h08 ? 4'h7 : 4'hf)});
            rd(`CCC_A_RESULT, v);
            chk(v, {30'h0, tk, 1'b0});
        end
        $display("test conditional call done");
        run(32'h12000000, 8'h0, 4'h0);
        chk(32'(cyc), 32'h0);
        rd(`CCC_A_RESULT, v);
        chk(v & 32'h4, 32'h4);
        $display("test illegal opcode done");
        results();
    end
endmodule

`default_nettype wire
